//--- pra_pkg.sv
// ------------------------------------------------------------
// Shared constants and types for the port rule access block
// ------------------------------------------------------------
package pra_pkg;

  // ----------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------
  localparam int unsigned NPORT = 7;        // Switch ports 1..7
  localparam int unsigned NBYTE = 16;       // Bytes per rule entry
  localparam int unsigned NENTRY = 16;      // Rule entries per port
  localparam int unsigned NCLASS = 5;       // Classifier sources

  // ----------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------
  localparam logic [11:0] IDX_SEL_LOW = 12'h611;   // rule_byte_select_low
  localparam logic [11:0] IDX_ACC_CTRL = 12'h612;  // rule_access_control
  localparam logic [11:0] IDX_MIRROR = 12'h800;    // port_mirror_control
  localparam logic [11:0] IDX_PRIO = 12'h801;      // port_priority_control
  localparam logic [2:0] PORT_FIRST = 3'h1;        // Lowest port number
  localparam logic [2:0] PORT_LAST = 3'h7;         // Highest port number

  // ----------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------
  localparam int unsigned ACC_WR_DONE_BIT = 6;     // Write complete flag
  localparam int unsigned ACC_RD_DONE_BIT = 5;     // Read complete flag
  localparam int unsigned ACC_DIR_BIT = 4;         // 1 write, 0 read
  localparam int unsigned ACC_IDX_MSB = 3;         // rule_entry_index top
  localparam int unsigned MIR_RX_BIT = 6;          // Receive monitor
  localparam int unsigned MIR_TX_BIT = 5;          // Transmit monitor
  localparam int unsigned MIR_SINK_BIT = 1;        // Monitoring port
  localparam int unsigned PRI_HIGHEST_BIT = 7;     // Highest of classes
  localparam int unsigned PRI_MERGE_BIT = 6;       // merge_class_bits
  localparam int unsigned PRI_MAC_BIT = 4;         // MAC classification
  localparam int unsigned PRI_VLAN_BIT = 3;        // VLAN classification
  localparam int unsigned PRI_PCP_BIT = 2;         // 802.1p classification
  localparam int unsigned PRI_DSCP_BIT = 1;        // Diffserv classification
  localparam int unsigned PRI_RULE_BIT = 0;        // Rule result classification

  // ----------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------
  localparam logic [7:0] SEL_LOW_RST = 8'h00;
  localparam logic [7:0] ACC_CTRL_RST = 8'h60;     // Both done flags high
  localparam logic [7:0] MIRROR_RST = 8'h00;
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic [7:0] MIRROR_WMASK = 8'h62;
  localparam logic [7:0] PRIO_WMASK = 8'hdf;

  // ----------------------------------------------------------
  // Timing: cycles a table access waits in ENG_BUSY once launched
  // ----------------------------------------------------------
  localparam logic [1:0] ENG_CYCLES = 2'h2;

  // ----------------------------------------------------------
  // Types
  // ----------------------------------------------------------
  typedef enum logic [1:0]
  {
    ENG_IDLE = 2'b00,
    ENG_BUSY = 2'b01,
    ENG_FIN = 2'b10
  } pra_eng_state_t;

  typedef enum logic [2:0]
  {
    RK_NONE = 3'b000,
    RK_SEL_LOW = 3'b001,
    RK_ACC_CTRL = 3'b010,
    RK_MIRROR = 3'b011,
    RK_PRIO = 3'b100
  } pra_reg_kind_t;

  // Decoded APB address
  typedef struct packed
  {
    logic hit;
    logic [2:0] port;
    pra_reg_kind_t kind;
  } pra_dec_t;

  // Classifier results for one port; index follows the control bits
  typedef struct packed
  {
    logic [NCLASS-1:0] hit;
    logic [NCLASS-1:0][2:0] level;
    logic [2:0] dflt;
  } pra_class_t;

  // Mirroring controls for one port
  typedef struct packed
  {
    logic rx_mon;
    logic tx_mon;
    logic sink;
  } pra_mirror_t;

  // Rule read answer toward the rule data registers
  typedef struct packed
  {
    logic load;
    logic [NBYTE-1:0] mask;
    logic [NBYTE*8-1:0] data;
  } pra_rule_rsp_t;

endpackage : pra_pkg

//--- pra_rule_engine.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Rule table of one port with masked indirect access
// ------------------------------------------------------------
module pra_rule_engine
  import pra_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Launch request
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [3:0] index_i,
  input wire logic [NBYTE-1:0] mask_i,
  input wire logic [NBYTE*8-1:0] wdata_i,
  // Status and answer
  output logic busy_o,
  output logic wr_fin_o,
  output logic rd_fin_o,
  output pra_rule_rsp_t rsp_o
);

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  pra_eng_state_t state_q;                  // Sequencer state
  logic [1:0] cnt_q;                        // Access wait count
  logic write_q;                            // Latched direction
  logic [3:0] index_q;                      // Latched entry
  logic [NBYTE-1:0] mask_q;                 // Latched byte mask
  logic [NBYTE*8-1:0] wdata_q;              // Latched write data
  logic [NENTRY-1:0][NBYTE*8-1:0] table_q;  // Rule storage

  // Busy seen by the register side
  assign busy_o = (state_q != ENG_IDLE);

  // Sequencer: launch, wait, finish
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ENG_IDLE;
      cnt_q <= 2'h0;
    end
    else
    begin
      case (state_q)
        ENG_IDLE:
        begin
          // Start only taken while idle
          if (start_i)
          begin
            state_q <= ENG_BUSY;
            cnt_q <= ENG_CYCLES;
          end
        end
        ENG_BUSY:
        begin
          // Count down the access time
          cnt_q <= cnt_q - 2'h1;
          if (cnt_q == 2'h1)
          begin
            state_q <= ENG_FIN;
          end
        end
        ENG_FIN:
        begin
          state_q <= ENG_IDLE;
        end
        default:
        begin
          state_q <= ENG_IDLE;
        end
      endcase
    end
  end

  // Request latch at launch
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      write_q <= 1'b0;
      index_q <= 4'h0;
      mask_q <= '0;
      wdata_q <= '0;
    end
    else if (start_i && (state_q == ENG_IDLE))
    begin
      write_q <= write_i;
      index_q <= index_i;
      mask_q <= mask_i;
      wdata_q <= wdata_i;
    end
  end

  // Table update, selected bytes only
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      table_q <= '0;
    end
    else if ((state_q == ENG_FIN) && write_q)
    begin
      for (int k = 0; k < NBYTE; k++)
      begin
        // Byte k sits at the top end for k = 0
        if (mask_q[k])
        begin
          table_q[index_q][(NBYTE-1-k)*8 +: 8] <= wdata_q[(NBYTE-1-k)*8 +: 8];
        end
      end
    end
  end

  // Completion pulses and read answer
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      wr_fin_o <= 1'b0;
      rd_fin_o <= 1'b0;
      rsp_o <= '0;
    end
    else
    begin
      wr_fin_o <= (state_q == ENG_FIN) && write_q;
      rd_fin_o <= (state_q == ENG_FIN) && !write_q;
      rsp_o.load <= (state_q == ENG_FIN) && !write_q;
      if ((state_q == ENG_FIN) && !write_q)
      begin
        rsp_o.mask <= mask_q;
        for (int k = 0; k < NBYTE; k++)
        begin
          // Unselected bytes come back as zero and are not loaded
          rsp_o.data[(NBYTE-1-k)*8 +: 8] <=
            mask_q[k] ? table_q[index_q][(NBYTE-1-k)*8 +: 8] : 8'h00;
        end
      end
    end
  end

endmodule : pra_rule_engine

//--- pra_port_regs.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module pra_port_regs
  import pra_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [16:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Neighbouring rule data and upper select registers
  input wire logic [NPORT-1:0][7:0] sel_high_i,
  input wire logic [NPORT-1:0][NBYTE*8-1:0] stage_data_i,
  output pra_rule_rsp_t [NPORT-1:0] rule_rsp_o,
  // Mirroring controls
  output pra_mirror_t [NPORT-1:0] mirror_o,
  // Ingress classification
  input wire pra_class_t [NPORT-1:0] class_i,
  output logic [NPORT-1:0][2:0] ingress_prio_o
);

  // ----------------------------------------------------------
  // Functions
  // ----------------------------------------------------------

  // Address decode, used for reads and writes
  function automatic pra_dec_t decode(input logic [14:0] idx);
    pra_dec_t d;
    d.port = idx[14:12];
    d.kind = RK_NONE;
    if (idx[11:0] == IDX_SEL_LOW)
    begin
      d.kind = RK_SEL_LOW;
    end
    else if (idx[11:0] == IDX_ACC_CTRL)
    begin
      d.kind = RK_ACC_CTRL;
    end
    else if (idx[11:0] == IDX_MIRROR)
    begin
      d.kind = RK_MIRROR;
    end
    else if (idx[11:0] == IDX_PRIO)
    begin
      d.kind = RK_PRIO;
    end
    d.hit = (d.kind != RK_NONE) && (d.port >= PORT_FIRST) && (d.port <= PORT_LAST);
    return d;
  endfunction : decode

  // Highest level among enabled hits
  function automatic logic [2:0] pick_max(input logic [NCLASS-1:0] hit,
                                          input logic [NCLASS-1:0][2:0] lvl);
    logic [2:0] m;
    m = 3'h0;
    for (int i = 0; i < NCLASS; i++)
    begin
      if (hit[i] && (lvl[i] > m))
      begin
        m = lvl[i];
      end
    end
    return m;
  endfunction : pick_max

  // Bitwise OR of enabled hits
  function automatic logic [2:0] merge_or(input logic [NCLASS-1:0] hit,
                                          input logic [NCLASS-1:0][2:0] lvl);
    logic [2:0] m;
    m = 3'h0;
    for (int i = 0; i < NCLASS; i++)
    begin
      if (hit[i])
      begin
        m = m | lvl[i];
      end
    end
    return m;
  endfunction : merge_or

  // First enabled hit, lowest bit first
  function automatic logic [2:0] pick_first(input logic [NCLASS-1:0] hit,
                                            input logic [NCLASS-1:0][2:0] lvl);
    logic [2:0] m;
    logic found;
    m = 3'h0;
    found = 1'b0;
    for (int i = 0; i < NCLASS; i++)
    begin
      if (hit[i] && !found)
      begin
        m = lvl[i];
        found = 1'b1;
      end
    end
    return m;
  endfunction : pick_first

  // ----------------------------------------------------------
  // APB front end
  // ----------------------------------------------------------
  pra_dec_t dec;                          // Current address decode
  logic [2:0] port_sel;                   // Zero-based port number
  logic acc_phase;                        // Access phase present
  logic wr_go;                            // Write commits this edge
  logic [31:0] rd_mux;                    // Read value of addressed reg

  assign dec = decode(paddr_i[16:2]);
  assign port_sel = dec.port - 3'h1;
  assign acc_phase = psel_i && penable_i;
  assign wr_go = acc_phase && pready_o && pwrite_i && dec.hit;

  // Ready one cycle into the access phase, read data captured with it
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else if (acc_phase && !pready_o)
    begin
      pready_o <= 1'b1;
      pslverr_o <= !dec.hit;
      prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
    end
    else
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Per-port registers
  // ----------------------------------------------------------
  logic [NPORT-1:0][7:0] sel_low_q;       // rule_byte_select_low
  logic [NPORT-1:0] dir_q;                // Direction, 1 write
  logic [NPORT-1:0][3:0] rule_entry_index_q;
  logic [NPORT-1:0] wr_done_q;            // Write complete flag
  logic [NPORT-1:0] rd_done_q;            // Read complete flag
  logic [NPORT-1:0][7:0] mirror_q;        // port_mirror_control
  logic [NPORT-1:0][7:0] prio_q;          // port_priority_control
  logic [NPORT-1:0] eng_busy;             // Engine busy per port
  logic [NPORT-1:0] eng_wr_fin;           // Write finished pulse
  logic [NPORT-1:0] eng_rd_fin;           // Read finished pulse
  logic [NPORT-1:0] launch;               // Accepted launch
  logic [NPORT-1:0][NBYTE-1:0] byte_mask; // Mask by byte number

  // Read mux for the addressed register
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (dec.hit)
    begin
      case (dec.kind)
        RK_SEL_LOW: rd_mux[7:0] = sel_low_q[port_sel];
        RK_ACC_CTRL:
        begin
          rd_mux[ACC_WR_DONE_BIT] = wr_done_q[port_sel];
          rd_mux[ACC_RD_DONE_BIT] = rd_done_q[port_sel];
          rd_mux[ACC_DIR_BIT] = dir_q[port_sel];
          rd_mux[ACC_IDX_MSB:0] = rule_entry_index_q[port_sel];
        end
        RK_MIRROR: rd_mux[7:0] = mirror_q[port_sel];
        RK_PRIO: rd_mux[7:0] = prio_q[port_sel];
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  genvar gp;
  genvar gb;
  generate
    for (gp = 0; gp < NPORT; gp++)
    begin : g_port
      logic hit_port;                     // Address targets this port
      logic [NCLASS-1:0] class_hit;       // Enabled and valid classes
      logic [2:0] prio_d;                 // Next ingress priority

      assign hit_port = (port_sel == 3'(gp));

      // Launch on low select write, ignored while busy
      assign launch[gp] = wr_go && hit_port && (dec.kind == RK_SEL_LOW) && !eng_busy[gp];

      // Byte mask: low half from the launching write data, bit i is byte F-i
      for (gb = 0; gb < 8; gb++)
      begin : g_map
        assign byte_mask[gp][NBYTE-1-gb] = pwdata_i[gb];
        assign byte_mask[gp][7-gb] = sel_high_i[gp][gb];
      end

      // Low select register
      always_ff @(posedge clk_sys_i)
      begin
        if (!rst_n_i)
        begin
          sel_low_q[gp] <= SEL_LOW_RST;
        end
        else if (wr_go && hit_port && (dec.kind == RK_SEL_LOW))
        begin
          sel_low_q[gp] <= pwdata_i[7:0];
        end
      end

      // Direction and entry index
      always_ff @(posedge clk_sys_i)
      begin
        if (!rst_n_i)
        begin
          dir_q[gp] <= ACC_CTRL_RST[ACC_DIR_BIT];
          rule_entry_index_q[gp] <= ACC_CTRL_RST[ACC_IDX_MSB:0];
        end
        else if (wr_go && hit_port && (dec.kind == RK_ACC_CTRL))
        begin
          dir_q[gp] <= pwdata_i[ACC_DIR_BIT];
          rule_entry_index_q[gp] <= pwdata_i[ACC_IDX_MSB:0];
        end
      end

      // Completion flags: flag of the launched direction cleared at launch, set when done, set wins
      always_ff @(posedge clk_sys_i)
      begin
        if (!rst_n_i)
        begin
          wr_done_q[gp] <= ACC_CTRL_RST[ACC_WR_DONE_BIT];
          rd_done_q[gp] <= ACC_CTRL_RST[ACC_RD_DONE_BIT];
        end
        else
        begin
          if (eng_wr_fin[gp])
          begin
            wr_done_q[gp] <= 1'b1;
          end
          else if (launch[gp] && dir_q[gp])
          begin
            wr_done_q[gp] <= 1'b0;
          end
          if (eng_rd_fin[gp])
          begin
            rd_done_q[gp] <= 1'b1;
          end
          else if (launch[gp] && !dir_q[gp])
          begin
            rd_done_q[gp] <= 1'b0;
          end
        end
      end

      // Mirroring and priority control, reserved bits stay zero
      always_ff @(posedge clk_sys_i)
      begin
        if (!rst_n_i)
        begin
          mirror_q[gp] <= MIRROR_RST;
          prio_q[gp] <= PRIO_RST;
        end
        else
        begin
          if (wr_go && hit_port && (dec.kind == RK_MIRROR))
          begin
            mirror_q[gp] <= pwdata_i[7:0] & MIRROR_WMASK;
          end
          if (wr_go && hit_port && (dec.kind == RK_PRIO))
          begin
            prio_q[gp] <= pwdata_i[7:0] & PRIO_WMASK;
          end
        end
      end

      // Rule table access for this port
      pra_rule_engine u_engine
      (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .start_i(launch[gp]),
        .write_i(dir_q[gp]),
        .index_i(rule_entry_index_q[gp]),
        .mask_i(byte_mask[gp]),
        .wdata_i(stage_data_i[gp]),
        .busy_o(eng_busy[gp]),
        .wr_fin_o(eng_wr_fin[gp]),
        .rd_fin_o(eng_rd_fin[gp]),
        .rsp_o(rule_rsp_o[gp])
      );

      // Mirroring outputs
      always_ff @(posedge clk_sys_i)
      begin
        if (!rst_n_i)
        begin
          mirror_o[gp] <= '0;
        end
        else
        begin
          mirror_o[gp].rx_mon <= mirror_q[gp][MIR_RX_BIT];
          mirror_o[gp].tx_mon <= mirror_q[gp][MIR_TX_BIT];
          mirror_o[gp].sink <= mirror_q[gp][MIR_SINK_BIT];
        end
      end

      // Each class counts only when its enable is set
      assign class_hit[PRI_MAC_BIT] = class_i[gp].hit[PRI_MAC_BIT] && prio_q[gp][PRI_MAC_BIT];
      assign class_hit[PRI_VLAN_BIT] = class_i[gp].hit[PRI_VLAN_BIT] && prio_q[gp][PRI_VLAN_BIT];
      assign class_hit[PRI_PCP_BIT] = class_i[gp].hit[PRI_PCP_BIT] && prio_q[gp][PRI_PCP_BIT];
      assign class_hit[PRI_DSCP_BIT] = class_i[gp].hit[PRI_DSCP_BIT] && prio_q[gp][PRI_DSCP_BIT];
      assign class_hit[PRI_RULE_BIT] = class_i[gp].hit[PRI_RULE_BIT] && prio_q[gp][PRI_RULE_BIT];

      // Priority resolution; default when nothing classifies
      always_comb
      begin
        if (class_hit == '0)
        begin
          prio_d = class_i[gp].dflt;
        end
        else if (prio_q[gp][PRI_HIGHEST_BIT])
        begin
          prio_d = pick_max(class_hit, class_i[gp].level);
        end
        else if (prio_q[gp][PRI_MERGE_BIT])
        begin
          prio_d = merge_or(class_hit, class_i[gp].level);
        end
        else
        begin
          prio_d = pick_first(class_hit, class_i[gp].level);
        end
      end

      // Registered ingress priority
      always_ff @(posedge clk_sys_i)
      begin
        if (!rst_n_i)
        begin
          ingress_prio_o[gp] <= 3'h0;
        end
        else
        begin
          ingress_prio_o[gp] <= prio_d;
        end
      end
    end
  endgenerate

endmodule : pra_port_regs

//--- pra_port_regs_chk.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port side checker
// ----------------------------------------
module pra_port_regs_chk
  import pra_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [16:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Port side
  input wire pra_rule_rsp_t [NPORT-1:0] rule_rsp_o,
  input wire pra_mirror_t [NPORT-1:0] mirror_o,
  input wire pra_class_t [NPORT-1:0] class_i,
  input wire logic [NPORT-1:0][2:0] ingress_prio_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // Access phase still waiting
  wire acc_w = psel_i && penable_i && !pready_o;
  // Commit of a port 2 mirroring write
  wire mir_w = acc_w == 1'b0 && psel_i && penable_i && pwrite_i && paddr_i == 17'h0a000;
  a_ready_one_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_one_wait_state: assert property (acc_w |=> pready_o)
    else $error("ready late");
  a_idle_no_ready: assert property (!psel_i |=> !pready_o)
    else $error("ready without request");
  a_err_needs_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_upper_bytes_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_err: assert property (acc_w && paddr_i[16:14] == 3'h0 |=> pslverr_o)
    else $error("port 0 not refused");
  a_mirror_follow: assert property (mir_w |-> ##2 mirror_o[1] ==
    {$past(pwdata_i[6], 2), $past(pwdata_i[5], 2), $past(pwdata_i[1], 2)})
    else $error("mirror output wrong");
  a_load_one_cycle: assert property (rule_rsp_o[0].load |=> !rule_rsp_o[0].load)
    else $error("load held");
  a_unsel_byte_zero: assert property (rule_rsp_o[0].load && !rule_rsp_o[0].mask[0]
    |-> rule_rsp_o[0].data[127:120] == 8'h0)
    else $error("unselected byte passed");
  a_prio_default: assert property (class_i[0].hit == 5'h0
    |=> ingress_prio_o[0] == $past(class_i[0].dflt))
    else $error("default priority wrong");
endmodule : pra_port_regs_chk

bind pra_port_regs pra_port_regs_chk u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .rule_rsp_o(rule_rsp_o), .mirror_o(mirror_o), .class_i(class_i),
  .ingress_prio_o(ingress_prio_o));

//--- pra_port_regs_bench.sv
`timescale 1ns/10ps
// ----------------------------------------
// Register bench
// ----------------------------------------
module pra_port_regs_bench
  import pra_pkg::*;
();
  logic clk_sys_i = 1'b0; // 100 MHz
  logic rst_n_i = 1'b0; // Active low
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [16:0] paddr_i = 17'h0;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [NPORT-1:0][7:0] sel_high_i = '0; // Upper select
  logic [NPORT-1:0][NBYTE*8-1:0] stage_data_i = '0; // Staged bytes
  pra_rule_rsp_t [NPORT-1:0] rule_rsp_o;
  pra_mirror_t [NPORT-1:0] mirror_o;
  pra_class_t [NPORT-1:0] class_i = '0;
  logic [NPORT-1:0][2:0] ingress_prio_o;
  pra_rule_rsp_t cap; // Last read answer
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  pra_port_regs u_pra_port_regs (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sel_high_i(sel_high_i), .stage_data_i(stage_data_i), .rule_rsp_o(rule_rsp_o),
    .mirror_o(mirror_o), .class_i(class_i), .ingress_prio_o(ingress_prio_o));
  // Clock
  always #5 clk_sys_i = ~clk_sys_i;
  // Keep read answer of port 1
  always @(posedge clk_sys_i)
    if (rule_rsp_o[0].load === 1'b1)
      cap <= rule_rsp_o[0];
  // Hang guard
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [16:0] adr(logic [2:0] p, logic [11:0] i);
    return {p, i, 2'b00};
  endfunction : adr
  // Bytes kept by a select pair
  function automatic logic [127:0] keep(logic [127:0] d, logic [15:0] s);
    logic [127:0] r;
    for (int k = 0; k < 16; k++)
      r[127-8*k -: 8] = s[15-k] ? d[127-8*k -: 8] : 8'h0;
    return r;
  endfunction : keep
  task automatic chk(input string n, input logic [127:0] x, input logic [127:0] g);
    checks_done++;
    if (g !== x)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // One APB transfer
  task automatic apb(input logic w, input logic [16:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1)
      @(posedge clk_sys_i);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  // Poll a done flag of port 1
  task automatic poll(input int b);
    logic [31:0] q;
    logic e;
    q = 32'h0;
    for (int n = 0; n < 20 && q[b] !== 1'b1; n++)
      apb(1'b0, adr(PORT_FIRST, IDX_ACC_CTRL), 32'h0, q, e);
    chk("done flag", 128'h1, q[b]);
  endtask : poll
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    logic [31:0] q;
    logic e;
    logic [127:0] pat;
    logic [15:0] m;
    logic [11:0] ri [4] = '{IDX_SEL_LOW, IDX_ACC_CTRL, IDX_MIRROR, IDX_PRIO};
    logic [7:0] rv [4] = '{8'h00, 8'h60, 8'h00, 8'h00};
    logic [7:0] mw [3] = '{8'hff, 8'h40, 8'h22};
    logic [2:0] me [3] = '{3'h7, 3'h4, 3'h3};
    logic [7:0] pw [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h83, 8'h43};
    logic [2:0] pe [8] = '{3'h3, 3'h4, 3'h1, 3'h6, 3'h2, 3'h5, 3'h4, 3'h5};
    for (int k = 0; k < 16; k++)
      pat[127-8*k -: 8] = 8'ha0 + 8'(k);
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    // Reset values and refused places
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, adr(PORT_FIRST, ri[i]), 32'h0, q, e);
      chk("reset value", rv[i], q);
    end
    apb(1'b0, adr(3'h0, IDX_SEL_LOW), 32'h0, q, e);
    chk("port 0 error", 128'h1, e);
    chk("port 0 data", 128'h0, q);
    apb(1'b1, adr(PORT_FIRST, 12'h613), 32'hff, q, e);
    chk("bad offset error", 128'h1, e);
    $display("test reset done");
    // Masked rule write then read
    stage_data_i[0] <= pat;
    sel_high_i[0] <= 8'h0f;
    apb(1'b1, adr(PORT_FIRST, IDX_ACC_CTRL), 32'h13, q, e);
    apb(1'b1, adr(PORT_FIRST, IDX_SEL_LOW), 32'h81, q, e);
    poll(ACC_WR_DONE_BIT);
    stage_data_i[0] <= ~pat;
    apb(1'b1, adr(PORT_FIRST, IDX_ACC_CTRL), 32'h03, q, e);
    apb(1'b1, adr(PORT_FIRST, IDX_SEL_LOW), 32'h81, q, e);
    poll(ACC_RD_DONE_BIT);
    chk("rule data", keep(pat, 16'h0f81), cap.data);
    for (int k = 0; k < 16; k++)
      m[k] = (k >= 4 && k <= 8) || k == 15;
    chk("rule mask", m, cap.mask);
    apb(1'b0, adr(PORT_FIRST, IDX_SEL_LOW), 32'h0, q, e);
    chk("select readback", 128'h81, q);
    $display("test rule access done");
    // Mirroring controls of port 2
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, adr(3'h2, IDX_MIRROR), mw[i], q, e);
      apb(1'b0, adr(3'h2, IDX_MIRROR), 32'h0, q, e);
      chk("mirror readback", mw[i] & 8'h62, q);
      chk("mirror out", me[i], mirror_o[1]);
    end
    chk("port 1 mirror", 128'h0, mirror_o[0]);
    $display("test mirror done");
    // Priority selection of port 1
    class_i[0].hit <= 5'h1f;
    class_i[0].level <= {3'h5, 3'h2, 3'h6, 3'h1, 3'h4};
    class_i[0].dflt <= 3'h3;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, adr(PORT_FIRST, IDX_PRIO), pw[i], q, e);
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk("priority", pe[i], ingress_prio_o[0]);
    end
    apb(1'b1, adr(PORT_FIRST, IDX_PRIO), 32'hff, q, e);
    apb(1'b0, adr(PORT_FIRST, IDX_PRIO), 32'h0, q, e);
    chk("priority readback", 128'hdf, q);
    class_i[0].hit <= 5'h0;
    repeat (3) @(posedge clk_sys_i);
    $display("test priority done");
    end_sim();
  end
endmodule : pra_port_regs_bench
